// File: core/lsd_defines.svh
// Constants for the lip-sync delay configuration block: register map, fields, limits.
// Assumes it is included by the package and by the core module, never compiled alone.
`ifndef LSD_DEFINES_SVH
`define LSD_DEFINES_SVH

// Byte addresses of the register file and the reset value of every register.
`define LSD_ADDR_FIRST 8'h01
`define LSD_ADDR_LAST 8'h08
`define LSD_REG_RESET 8'h00

// Register slots, counted from the first address.
`define LSD_IDX_CTRL 3'h0
`define LSD_IDX_RDLY_HI 3'h1
`define LSD_IDX_RDLY_LO 3'h2
`define LSD_IDX_LDLY_HI 3'h3
`define LSD_IDX_LDLY_LO 3'h4
`define LSD_IDX_FRAME 3'h5
`define LSD_IDX_WLEN 3'h6
`define LSD_IDX_COMMIT 3'h7

// Field positions.
`define LSD_CTRL_MUTE_L 6
`define LSD_CTRL_MUTE_R 7
`define LSD_FRAME_EN 7
`define LSD_FRAME_NTSC 6
`define LSD_COMMIT_BIT 0

// Widths and limits.
`define LSD_DLY_W 13
`define LSD_SMP_W 24
`define LSD_DLY_MAX 13'h1fff
`define LSD_WLEN_MAX 6'h18
`define LSD_FIFO_DEPTH 8

// Sample rates in Hz and the frame-rate divisors.
`define LSD_FS_32K 32'h0000_7d00
`define LSD_FS_44K1 32'h0000_ac44
`define LSD_FS_48K 32'h0000_bb80
`define LSD_FS_88K2 32'h0001_5888
`define LSD_FS_96K 32'h0001_7700
`define LSD_FS_176K4 32'h0002_b110
`define LSD_FS_192K 32'h0002_ee00
`define LSD_PAL_RATE 32'h0000_0032
`define LSD_NTSC_NUM 32'h0000_03e9
`define LSD_NTSC_DEN 32'h0000_ea60

`endif

// File: core/lsd_pkg.sv
// Types shared by the lip-sync delay configuration block and its testbench.
// Assumes lsd_defines.svh is on the include path.
`include "lsd_defines.svh"

package lsd_pkg;

  // Serial stream formats in register code order.
  typedef enum logic [1:0] {
    lsd_fmt_i2s,
    lsd_fmt_right_aligned_format,
    lsd_fmt_left_aligned,
    lsd_fmt_bypass
  } lsd_fmt_t;

  // Settings handed to the delay datapath on commit.
  typedef struct packed {
    lsd_fmt_t fmt;
    logic [`LSD_DLY_W-1:0] dly_r;
    logic [`LSD_DLY_W-1:0] dly_l;
    logic [5:0] wlen;
  } lsd_cfg_t;

  // One received audio sample, left-aligned in 24 bits.
  typedef struct packed {
    logic chan_left;
    logic [`LSD_SMP_W-1:0] data;
  } lsd_smp_t;

  // Whole state of the core module.
  typedef struct packed {
    logic [7:0][7:0] regs;
    logic [7:0] ptr;
    logic [7:0] rd_data;
    lsd_cfg_t act;
    logic [2:0] bclk_s;
    logic [1:0] lrclk_s;
    logic [1:0] data_s;
    logic lr_cur;
    logic [`LSD_SMP_W-1:0] sh;
    logic [4:0] cnt;
    lsd_smp_t pend;
    logic pend_v;
    logic [1:0][`LSD_DLY_W-1:0] wcnt;
  } lsd_core_st_t;

endpackage

// File: core/lsd_fifo.sv
// Synchronous FIFO with valid and ready on both sides.
// Assumes one clock and an asynchronous active-low reset shared with its user.
`timescale 1ns/1ps

module lsd_fifo #(
  parameter int WIDTH = 25,
  parameter int DEPTH = 8
) (
  input wire logic sys_clk_i, // System clock.
  input wire logic arst_n_i, // Asynchronous reset, active low.
  input wire logic [WIDTH-1:0] in_data_i, // Word to store.
  input wire logic in_valid_i, // Word offered.
  output logic in_ready_o, // Room for a word.
  output logic [WIDTH-1:0] out_data_o, // Oldest word.
  output logic out_valid_o, // A word is held.
  input wire logic out_ready_i // Drain accepts the word.
);

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wptr;
    logic [AW-1:0] rptr;
    logic [AW:0] cnt;
  } lsd_fifo_st_t;

  lsd_fifo_st_t st_q;
  lsd_fifo_st_t nxt_st;
  logic push;
  logic pop;

  ////////////////////////////////////////////////////////////////////////////
  // Full and empty come straight from the occupancy count.
  assign in_ready_o = (st_q.cnt != (AW+1)'(DEPTH));
  assign out_valid_o = (st_q.cnt != '0);
  assign out_data_o = st_q.mem[st_q.rptr];
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;

  // Next state: store on push, advance on pop, both may happen together.
  always_comb begin
    nxt_st = st_q;
    if (push) begin
      nxt_st.mem[st_q.wptr] = in_data_i;
      nxt_st.wptr = AW'((st_q.wptr == AW'(DEPTH-1)) ? 0 : st_q.wptr + 1'b1);
    end
    if (pop) begin
      nxt_st.rptr = AW'((st_q.rptr == AW'(DEPTH-1)) ? 0 : st_q.rptr + 1'b1);
    end
    nxt_st.cnt = st_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  // State register.
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_q <= '0;
    end else begin
      st_q <= nxt_st;
    end
  end

endmodule

// File: core/lsd_core.sv
// Configuration register file and delay-setting logic of a stereo lip-sync delay.
// Assumes a byte-level register port from the control-bus slave on sys_clk_i, and
// bit clock, word clock and data pins from the audio source in another domain.
//
// Summary of operation
// - Control bits 7:6 mute: 00 none, 01 left, 10 right, 11 both.
// - Control bits 1:0 pick I2S, right-aligned, left-aligned or bypass without delay.
// - Each delay is 13 bits from a 5-bit high and 8-bit low byte.
// - Largest delay is 8191 samples, all thirteen bits set.
// - Delay zero adds nothing; delay one adds exactly one sample period.
// - Frame register bit 7 selects frame-based delay instead of sample registers.
// - Frame register bit 6 picks 50 Hz or 59.94 Hz frame rate.
// - Bits 5:3 code 32 to 192 kHz; codes 110 and 111 mean 192.
// - Bits 2:0 give frames to delay as field value plus one.
// - Frame delay equals integer of frames times sample rate over frame rate.
// - Frame delay above 8191 saturates to 8191.
// - Word width field 5:0 gives data bits, used in right-aligned format only.
// - Word width above 24 is treated as 24.
// - Staged delays become active only when commit bit 0 is written 1.
// - After commit each channel is muted until its delay in samples passed.
// - Mute bits act at once, with no commit needed.
// - Eight byte registers at 0x01 to 0x08, all reset to zero.
// - Data is sampled on bit clock rising edges; word clock runs at fs.
// - Burst writes land at consecutive addresses from the address sent.
// - Commit moves format, chosen delays and word width together.
`timescale 1ns/1ps
`include "lsd_defines.svh"

module lsd_core (
  input wire logic sys_clk_i, // System clock, 200 MHz.
  input wire logic arst_n_i, // Asynchronous reset, active low.
  input wire logic bclk_i, // Audio bit clock pin.
  input wire logic lrclk_i, // Audio word clock pin.
  input wire logic data_i, // Audio serial data pin.
  input wire logic ptr_load_i, // Pulse: byte_data_i is a register address.
  input wire logic byte_wr_i, // Pulse: write byte_data_i at the pointer.
  input wire logic [7:0] byte_data_i, // Address or data byte.
  input wire logic byte_rd_i, // Pulse: read the byte at the pointer.
  output logic [7:0] rd_data_o, // Byte read, valid the cycle after.
  output lsd_pkg::lsd_cfg_t act_cfg_o, // Settings in force in the datapath.
  output lsd_pkg::lsd_smp_t smp_o, // Received sample, muted as needed.
  output logic smp_valid_o, // Sample held for the datapath.
  input wire logic smp_ready_i // Datapath takes the sample.
);
  import lsd_pkg::*;

  lsd_core_st_t st_q;
  lsd_core_st_t nxt_st;
  lsd_cfg_t staged_c;
  lsd_smp_t wsmp_c;
  logic wd_c;
  logic rise_c;
  logic commit_c;
  logic fifo_ready;
  logic [`LSD_SMP_W-1:0] osh_c;
  logic [4:0] ocnt_c;
  logic [4:0] width_c;
  logic keep_all_c;
  logic i2s_like_c;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers.

  // Delay in samples for a frame register value, clamped to the maximum.
  function automatic logic [`LSD_DLY_W-1:0] frame_delay(input logic [7:0] f);
    logic [31:0] fs;
    logic [31:0] num;
    logic [31:0] q;
    unique case (f[5:3])
      3'h0: fs = `LSD_FS_32K;
      3'h1: fs = `LSD_FS_44K1;
      3'h2: fs = `LSD_FS_48K;
      3'h3: fs = `LSD_FS_88K2;
      3'h4: fs = `LSD_FS_96K;
      3'h5: fs = `LSD_FS_176K4;
      3'h6, 3'h7: fs = `LSD_FS_192K;
    endcase
    num = fs * ({29'h0, f[2:0]} + 32'h0000_0001);
    if (f[`LSD_FRAME_NTSC]) begin
      q = (num * `LSD_NTSC_NUM) / `LSD_NTSC_DEN;
    end else begin
      q = num / `LSD_PAL_RATE;
    end
    if (q > {19'h0, `LSD_DLY_MAX}) begin
      frame_delay = `LSD_DLY_MAX;
    end else begin
      frame_delay = q[`LSD_DLY_W-1:0];
    end
  endfunction

  // Shift one bit into a word; stops after 24 bits unless all bits are kept.
  function automatic logic [28:0] shift_in(input logic [23:0] sh, input logic [4:0] cnt,
                                           input logic d, input logic keep_all);
    logic [4:0] c;
    c = (cnt == 5'(`LSD_WLEN_MAX)) ? cnt : cnt + 5'h1;
    if (keep_all || cnt < 5'(`LSD_WLEN_MAX)) begin
      shift_in = {sh[22:0], d, c};
    end else begin
      shift_in = {sh, cnt};
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Staged settings decoded from the register file.
  always_comb begin
    staged_c.fmt = lsd_fmt_t'(st_q.regs[`LSD_IDX_CTRL][1:0]);
    if (st_q.regs[`LSD_IDX_WLEN][5:0] > `LSD_WLEN_MAX) begin
      staged_c.wlen = `LSD_WLEN_MAX;
    end else begin
      staged_c.wlen = st_q.regs[`LSD_IDX_WLEN][5:0];
    end
    if (staged_c.fmt == lsd_fmt_bypass) begin
      staged_c.dly_r = '0;
      staged_c.dly_l = '0;
    end else if (st_q.regs[`LSD_IDX_FRAME][`LSD_FRAME_EN]) begin
      staged_c.dly_r = frame_delay(st_q.regs[`LSD_IDX_FRAME]);
      staged_c.dly_l = frame_delay(st_q.regs[`LSD_IDX_FRAME]);
    end else begin
      staged_c.dly_r = {st_q.regs[`LSD_IDX_RDLY_HI][4:0], st_q.regs[`LSD_IDX_RDLY_LO]};
      staged_c.dly_l = {st_q.regs[`LSD_IDX_LDLY_HI][4:0], st_q.regs[`LSD_IDX_LDLY_LO]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state of the whole block.
  always_comb begin
    nxt_st = st_q;
    wd_c = 1'b0;
    wsmp_c = '0;
    osh_c = st_q.sh;
    ocnt_c = st_q.cnt;
    width_c = st_q.cnt;
    keep_all_c = (st_q.act.fmt == lsd_fmt_right_aligned_format);
    i2s_like_c = (st_q.act.fmt == lsd_fmt_i2s) || (st_q.act.fmt == lsd_fmt_bypass);

    // Pin synchronisers; the first stage only feeds the second.
    nxt_st.bclk_s = {st_q.bclk_s[1:0], bclk_i};
    nxt_st.lrclk_s = {st_q.lrclk_s[0], lrclk_i};
    nxt_st.data_s = {st_q.data_s[0], data_i};
    rise_c = st_q.bclk_s[1] & ~st_q.bclk_s[2];

    // Deserialiser: a word ends at the bit clock rise that sees a word clock change.
    if (rise_c) begin
      nxt_st.lr_cur = st_q.lrclk_s[1];
      if (st_q.lrclk_s[1] == st_q.lr_cur) begin
        {nxt_st.sh, nxt_st.cnt} = shift_in(st_q.sh, st_q.cnt, st_q.data_s[1], keep_all_c);
      end else begin
        wd_c = 1'b1;
        if (i2s_like_c) begin
          // The first rise after the change still carries the old word's last bit.
          {osh_c, ocnt_c} = shift_in(st_q.sh, st_q.cnt, st_q.data_s[1], 1'b0);
          nxt_st.sh = '0;
          nxt_st.cnt = 5'h0;
        end else begin
          nxt_st.sh = {23'h0, st_q.data_s[1]};
          nxt_st.cnt = 5'h1;
        end
        width_c = keep_all_c ? st_q.act.wlen[4:0] : ocnt_c;
        wsmp_c.data = osh_c << (5'(`LSD_WLEN_MAX) - width_c);
        wsmp_c.chan_left = i2s_like_c ? ~st_q.lr_cur : st_q.lr_cur;
      end
    end

    // Muting and warm-up after a commit, one counter per channel.
    if (wd_c) begin
      for (int c = 0; c < 2; c++) begin
        if (wsmp_c.chan_left == c[0]) begin
          if (st_q.wcnt[c] < (c[0] ? st_q.act.dly_l : st_q.act.dly_r)) begin
            nxt_st.wcnt[c] = st_q.wcnt[c] + 13'h0001;
            wsmp_c.data = '0;
          end
        end
      end
      if (wsmp_c.chan_left ? st_q.regs[`LSD_IDX_CTRL][`LSD_CTRL_MUTE_L]
                           : st_q.regs[`LSD_IDX_CTRL][`LSD_CTRL_MUTE_R]) begin
        wsmp_c.data = '0;
      end
    end

    // Holding slot in front of the FIFO; a newer word replaces one not yet taken.
    if (st_q.pend_v && fifo_ready) begin
      nxt_st.pend_v = 1'b0;
    end
    if (wd_c) begin
      nxt_st.pend = wsmp_c;
      nxt_st.pend_v = 1'b1;
    end

    // Commit moves all staged settings at once and clears its own bit.
    commit_c = st_q.regs[`LSD_IDX_COMMIT][`LSD_COMMIT_BIT];
    if (commit_c) begin
      nxt_st.act = staged_c;
      nxt_st.wcnt = '0;
      nxt_st.regs[`LSD_IDX_COMMIT][`LSD_COMMIT_BIT] = 1'b0;
    end

    // Register port; a write in the commit cycle wins over the self-clear.
    if (ptr_load_i) begin
      nxt_st.ptr = byte_data_i;
    end else if (byte_wr_i) begin
      if (st_q.ptr >= `LSD_ADDR_FIRST && st_q.ptr <= `LSD_ADDR_LAST) begin
        nxt_st.regs[3'(st_q.ptr - `LSD_ADDR_FIRST)] = byte_data_i;
      end
      nxt_st.ptr = st_q.ptr + 8'h01;
    end else if (byte_rd_i) begin
      if (st_q.ptr >= `LSD_ADDR_FIRST && st_q.ptr <= `LSD_ADDR_LAST) begin
        nxt_st.rd_data = st_q.regs[3'(st_q.ptr - `LSD_ADDR_FIRST)];
      end else begin
        nxt_st.rd_data = 8'h00;
      end
      nxt_st.ptr = st_q.ptr + 8'h01;
    end
  end

  // State register; every field resets to zero.
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_q <= '0;
    end else begin
      st_q <= nxt_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sample FIFO between the deserialiser and the delay datapath.
  lsd_fifo #(
    .WIDTH($bits(lsd_smp_t)),
    .DEPTH(`LSD_FIFO_DEPTH)
  ) u_fifo (
    .sys_clk_i(sys_clk_i),
    .arst_n_i(arst_n_i),
    .in_data_i(st_q.pend),
    .in_valid_i(st_q.pend_v),
    .in_ready_o(fifo_ready),
    .out_data_o(smp_o),
    .out_valid_o(smp_valid_o),
    .out_ready_i(smp_ready_i)
  );

  // Register-sourced outputs.
  assign rd_data_o = st_q.rd_data;
  assign act_cfg_o = st_q.act;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!arst_n_i);

  chk_mute_bits: assert property (
    wd_c && wsmp_c.chan_left && st_q.regs[`LSD_IDX_CTRL][`LSD_CTRL_MUTE_L]
    |=> st_q.pend_v && st_q.pend.chan_left && st_q.pend.data == '0)
    else $error("muted left word was not zero");

  chk_fmt_commit: assert property (
    commit_c |=> st_q.act.fmt == lsd_fmt_t'($past(st_q.regs[`LSD_IDX_CTRL][1:0])))
    else $error("committed format differs from control register");

  chk_delay_pack: assert property (
    commit_c && !st_q.regs[`LSD_IDX_FRAME][`LSD_FRAME_EN]
    && st_q.regs[`LSD_IDX_CTRL][1:0] != 2'h3
    |=> st_q.act.dly_l == {$past(st_q.regs[`LSD_IDX_LDLY_HI][4:0]),
                           $past(st_q.regs[`LSD_IDX_LDLY_LO])})
    else $error("left delay not built from its two bytes");

  chk_frame_conv: assert property (
    commit_c && st_q.regs[`LSD_IDX_FRAME] == 8'h90 && st_q.regs[`LSD_IDX_CTRL][1:0] != 2'h3
    |=> st_q.act.dly_l == 13'h03c0 && st_q.act.dly_r == 13'h03c0)
    else $error("one frame at 48 kHz and 50 Hz is not 960 samples");

  chk_frame_clamp: assert property (
    commit_c && st_q.regs[`LSD_IDX_FRAME][7:5] == 3'h7 && st_q.regs[`LSD_IDX_FRAME][2:0] == 3'h7
    && st_q.regs[`LSD_IDX_CTRL][1:0] != 2'h3
    |=> st_q.act.dly_r == `LSD_DLY_MAX)
    else $error("oversized frame delay not saturated");

  chk_wlen_clamp: assert property (
    commit_c && st_q.regs[`LSD_IDX_WLEN][5:0] > `LSD_WLEN_MAX |=> st_q.act.wlen == `LSD_WLEN_MAX)
    else $error("word width above 24 not limited");

  chk_commit_only: assert property (
    !commit_c |=> $stable(st_q.act))
    else $error("active settings changed without commit");

  chk_commit_clear: assert property (
    commit_c && !byte_wr_i |=> !st_q.regs[`LSD_IDX_COMMIT][`LSD_COMMIT_BIT] ##1 $stable(st_q.act))
    else $error("commit bit did not clear itself");

  chk_warm_mute: assert property (
    wd_c && !wsmp_c.chan_left && st_q.wcnt[0] < st_q.act.dly_r
    |=> st_q.pend.data == '0 && st_q.wcnt[0] == $past(st_q.wcnt[0]) + 13'h0001)
    else $error("right channel not muted during warm-up");

  chk_auto_inc: assert property (
    byte_wr_i && !ptr_load_i |=> st_q.ptr == $past(st_q.ptr) + 8'h01)
    else $error("write pointer did not advance");

  chk_mute_right: assert property (
    wd_c && !wsmp_c.chan_left && st_q.regs[`LSD_IDX_CTRL][`LSD_CTRL_MUTE_R]
    |=> st_q.pend_v && !st_q.pend.chan_left && st_q.pend.data == '0)
    else $error("muted right word was not zero");

  chk_sample_mask: assert property (
    commit_c && !st_q.regs[`LSD_IDX_FRAME][`LSD_FRAME_EN]
    && st_q.regs[`LSD_IDX_CTRL][1:0] != 2'h3
    |=> st_q.act.dly_r == {$past(st_q.regs[`LSD_IDX_RDLY_HI][4:0]),
                           $past(st_q.regs[`LSD_IDX_RDLY_LO])})
    else $error("right delay not taken from its two bytes");

  chk_frame_rate: assert property (
    commit_c && st_q.regs[`LSD_IDX_FRAME] == 8'hd2 && st_q.regs[`LSD_IDX_CTRL][1:0] != 2'h3
    |=> st_q.act.dly_l == 13'h0962)
    else $error("three frames at 48 kHz and 59.94 Hz are not 2402 samples");

  chk_rate_code: assert property (
    commit_c && st_q.regs[`LSD_IDX_FRAME] == 8'h80 && st_q.regs[`LSD_IDX_CTRL][1:0] != 2'h3
    |=> st_q.act.dly_r == 13'h0280)
    else $error("one frame at 32 kHz and 50 Hz is not 640 samples");

  chk_frame_count: assert property (
    commit_c && st_q.regs[`LSD_IDX_FRAME] == 8'h9b && st_q.regs[`LSD_IDX_CTRL][1:0] != 2'h3
    |=> st_q.act.dly_r == 13'h1b90)
    else $error("four frames at 88.2 kHz and 50 Hz are not 7056 samples");

  chk_wlen_pass: assert property (
    commit_c && st_q.regs[`LSD_IDX_WLEN][5:0] <= `LSD_WLEN_MAX
    |=> st_q.act.wlen == $past(st_q.regs[`LSD_IDX_WLEN][5:0]))
    else $error("word width in range not passed unchanged");

  chk_unmapped_read: assert property (
    byte_rd_i && !byte_wr_i && !ptr_load_i
    && (st_q.ptr < `LSD_ADDR_FIRST || st_q.ptr > `LSD_ADDR_LAST) |=> st_q.rd_data == 8'h00)
    else $error("unmapped address did not read as zero");

  chk_reg_write: assert property (
    byte_wr_i && !ptr_load_i && st_q.ptr >= `LSD_ADDR_FIRST && st_q.ptr <= `LSD_ADDR_LAST
    |=> st_q.regs[3'($past(st_q.ptr) - `LSD_ADDR_FIRST)] == $past(byte_data_i))
    else $error("written byte not stored at the pointer");

  chk_no_warmup: assert property (
    wd_c && !wsmp_c.chan_left && st_q.act.dly_r == '0
    |=> st_q.wcnt[0] == '0)
    else $error("zero delay still counted warm-up words");

  cov_commit: cover property (commit_c ##1 st_q.act.dly_l != '0);
  cov_frame_mode: cover property (commit_c && st_q.regs[`LSD_IDX_FRAME][`LSD_FRAME_EN]);
  cov_fifo_full: cover property (st_q.pend_v && !fifo_ready);
  cov_burst: cover property (byte_wr_i ##1 byte_wr_i ##1 byte_wr_i);

endmodule

// File: sim/lsd_audio_src.sv
// Behavioural serial audio source for the lip-sync delay configuration block.
// Assumes I2S framing: 32 bit clocks per slot, left word while the word clock is low.
`timescale 1ns/1ps

module lsd_audio_src (
  input wire logic go_i, // Rising edge starts a burst.
  input wire logic [7:0] slots_i, // Slots in the burst.
  output logic busy_o, // High while a burst runs.
  output logic bclk_o, // Bit clock, still between bursts.
  output logic lrclk_o, // Word clock, one slot per level.
  output logic data_o // Serial data.
);
  int seq;
  logic [23:0] word;

  ////////////////////////////////////////////////////////////////////////////////
  // Slot zero carries zeros, so its alignment after reset does not matter.
  // Data and word clock move on the falling edge and are taken on the rise.
  initial begin
    seq = 0;
    busy_o = 1'b0;
    bclk_o = 1'b0;
    lrclk_o = 1'b0;
    data_o = 1'b0;
    forever begin
      @(posedge go_i);
      #1;
      busy_o = 1'b1;
      repeat (slots_i) begin
        word = (seq == 0) ? 24'h00_0000 : {8'ha5, seq[15:0]};
        for (int b = 0; b < 32; b++) begin
          if (b == 0) lrclk_o = seq[0];
          data_o = (b >= 1 && b <= 24) ? word[24-b] : b[0];
          #24 bclk_o = 1'b1;
          #24 bclk_o = 1'b0;
        end
        seq++;
      end
      // The line is released: show the inverse so no stale bit looks valid.
      data_o = ~data_o;
      busy_o = 1'b0;
    end
  end
endmodule

// File: sim/lsd_core_test.sv
// Self-checking testbench of the lip-sync delay configuration core.
// Assumes lsd_pkg, lsd_fifo, lsd_core and lsd_audio_src are compiled before it.
`timescale 1ns/1ps
`include "lsd_defines.svh"

module lsd_core_test;
  import lsd_pkg::*;

  logic sys_clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic bclk, lrclk, sdata, busy, go = 1'b0, ptr_load = 1'b0, byte_wr = 1'b0, byte_rd = 1'b0;
  logic smp_ready = 1'b0, lj = 1'b0;
  logic [7:0] slots = 8'h00, bdata = 8'h00, rd_data;
  lsd_cfg_t act_cfg;
  lsd_smp_t smp;
  logic smp_valid;
  int mismatches = 0, compares = 0, nxt = 0, zl, zr, sh1 = 0;
  longint fsr [8], e;

  always #2.5 sys_clk_i = ~sys_clk_i;

  lsd_core dut (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .bclk_i(bclk), .lrclk_i(lrclk),
    .data_i(sdata), .ptr_load_i(ptr_load), .byte_wr_i(byte_wr), .byte_data_i(bdata),
    .byte_rd_i(byte_rd), .rd_data_o(rd_data), .act_cfg_o(act_cfg), .smp_o(smp),
    .smp_valid_o(smp_valid), .smp_ready_i(smp_ready));

  lsd_audio_src src (.go_i(go), .slots_i(slots), .busy_o(busy), .bclk_o(bclk),
    .lrclk_o(lrclk), .data_o(sdata));

  ////////////////////////////////////////////////////////////////////////////////
  // Comparison, verdict and register-port tasks.
  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic results();
    if (mismatches == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // One request per edge; each strobe is assigned once per edge.
  task automatic op(input logic [1:0] k, input logic [7:0] d);
    @(posedge sys_clk_i);
    ptr_load <= (k == 2'h1);
    byte_wr <= (k == 2'h2);
    byte_rd <= (k == 2'h3);
    bdata <= d;
  endtask

  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    op(2'h1, a);
    op(2'h2, d);
    op(2'h0, 8'h00);
  endtask

  task automatic rreg(input logic [7:0] a, input logic [7:0] exp);
    op(2'h1, a);
    op(2'h3, 8'h00);
    op(2'h0, 8'h00);
    @(posedge sys_clk_i);
    #1;
    chk(34'(rd_data), 34'(exp));
  endtask

  // Commit, then compare the active settings once they have landed.
  task automatic commit(input logic [33:0] exp, input logic [33:0] mask);
    wreg(8'h08, 8'h01);
    repeat (2) @(posedge sys_clk_i);
    #1;
    chk(act_cfg & mask, exp & mask);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Audio bursts and sample collection.
  task automatic burst(input int n);
    int t;
    @(posedge sys_clk_i);
    slots <= n[7:0];
    go <= 1'b1;
    @(posedge sys_clk_i);
    go <= 1'b0;
    t = 0;
    while (busy === 1'b1 && t < 20000) begin
      @(posedge sys_clk_i);
      t++;
    end
    if (t >= 20000) mismatches++;
  endtask

  // Takes the next word and compares it with the slot it must come from.
  task automatic get(input logic z);
    int t;
    logic [23:0] w;
    w = (nxt == 0 || z) ? 24'h00_0000 : {8'ha5, nxt[15:0]} >> sh1;
    t = 0;
    #1;
    while (smp_valid !== 1'b1 && t < 2000) begin
      @(posedge sys_clk_i);
      #1;
      t++;
    end
    if (t >= 2000) mismatches++;
    chk(34'(smp), 34'({lj ? nxt[0] : ~nxt[0], w}));
    @(posedge sys_clk_i);
    smp_ready <= 1'b1;
    @(posedge sys_clk_i);
    smp_ready <= 1'b0;
    nxt++;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    fsr = '{`LSD_FS_32K, `LSD_FS_44K1, `LSD_FS_48K, `LSD_FS_88K2, `LSD_FS_96K,
      `LSD_FS_176K4, `LSD_FS_192K, `LSD_FS_192K};
    repeat (20) @(posedge sys_clk_i);
    arst_n_i <= 1'b1;
    for (int a = 1; a <= 8; a++) rreg(8'(a), 8'h00);
    chk(34'(act_cfg), 34'h0_0000_0000);
    // Plain stream: dummy slot, then alternating channels.
    burst(4);
    for (int i = 0; i < 3; i++) get(1'b0);
    // Every mute code, written without commit.
    for (int m = 0; m < 4; m++) begin
      wreg(8'h01, 8'(m << 6));
      burst(2);
      for (int i = 0; i < 2; i++) get(nxt[0] ? m[1] : m[0]);
    end
    // Warm-up after commit: right delay 1, left delay 2.
    op(2'h1, 8'h01);
    op(2'h2, 8'h00);
    op(2'h2, 8'h00);
    op(2'h2, 8'h01);
    op(2'h2, 8'h00);
    op(2'h2, 8'h02);
    op(2'h0, 8'h00);
    commit({lsd_fmt_i2s, 13'h0001, 13'h0002, 6'h00}, '1);
    zl = 2;
    zr = 1;
    burst(6);
    for (int i = 0; i < 6; i++) begin
      if (nxt[0]) begin
        get(zr > 0);
        zr--;
      end else begin
        get(zl > 0);
        zl--;
      end
    end
    // Stalled drain: eight held, the ninth word replaced by the tenth.
    burst(10);
    for (int i = 0; i < 8; i++) get(1'b0);
    nxt++;
    get(1'b0);
    // Left-aligned, zero delays: word high means left; the word begun before
    // the switch keeps all 24 bits, later ones lose their last bit.
    op(2'h1, 8'h01);
    op(2'h2, 8'h02);
    for (int i = 0; i < 4; i++) op(2'h2, 8'h00);
    op(2'h0, 8'h00);
    commit({lsd_fmt_left_aligned, 13'h0000, 13'h0000, 6'h00}, '1);
    lj = 1'b1;
    burst(3);
    get(1'b0);
    sh1 = 1;
    for (int i = 0; i < 2; i++) get(1'b0);
    // Staged writes stay inactive until commit.
    op(2'h1, 8'h01);
    op(2'h2, 8'h01);
    op(2'h2, 8'hff);
    op(2'h2, 8'hff);
    op(2'h2, 8'h00);
    op(2'h2, 8'h23);
    op(2'h2, 8'h00);
    op(2'h2, 8'h1e);
    op(2'h0, 8'h00);
    repeat (2) @(posedge sys_clk_i);
    chk(34'(act_cfg), {lsd_fmt_left_aligned, 13'h0000, 13'h0000, 6'h00});
    rreg(8'h02, 8'hff);
    rreg(8'h07, 8'h1e);
    commit({lsd_fmt_right_aligned_format, `LSD_DLY_MAX, 13'h0023, `LSD_WLEN_MAX}, '1);
    rreg(8'h08, 8'h00);
    wreg(8'h07, 8'h10);
    commit({lsd_fmt_right_aligned_format, `LSD_DLY_MAX, 13'h0023, 6'h10}, '1);
    // Frame mode over both frame rates and every rate code.
    for (int r = 0; r < 2; r++) begin
      for (int c = 0; c < 8; c++) begin
        e = (r == 1) ? longint'(c + 1) * fsr[c] * `LSD_NTSC_NUM / `LSD_NTSC_DEN
          : longint'(c + 1) * fsr[c] / `LSD_PAL_RATE;
        if (e > `LSD_DLY_MAX) e = `LSD_DLY_MAX;
        wreg(8'h06, {1'b1, r[0], c[2:0], c[2:0]});
        commit({lsd_fmt_right_aligned_format, e[12:0], e[12:0], 6'h10}, '1);
      end
    end
    wreg(8'h06, 8'h90);
    commit({lsd_fmt_right_aligned_format, 13'h03c0, 13'h03c0, 6'h10}, '1);
    wreg(8'h06, 8'h7f);
    commit({lsd_fmt_right_aligned_format, `LSD_DLY_MAX, 13'h0023, 6'h10}, '1);
    wreg(8'h01, 8'h03);
    commit({lsd_fmt_bypass, 13'h0000, 13'h0000, 6'h00}, {28'hfff_ffff, 6'h00});
    // Unmapped places ignore writes and read as zero.
    wreg(8'h09, 8'h55);
    rreg(8'h09, 8'h00);
    wreg(8'h00, 8'haa);
    rreg(8'h00, 8'h00);
    results();
  end

  // Watchdog well beyond the expected run of about 50 us.
  initial begin
    #(300us);
    mismatches++;
    results();
  end
endmodule
